/* File: design/can_crc_filter_bit_timing.sv */
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - capture CRC of last classical frame sent successfully, read-only bits 14:0.
// - record sending mailbox number with that CRC, read-only bits 20:16.
// - common FIFO mask bit 1 compares the element bit, 0 ignores it.
// - report lowest matching filter element for FIFO output message, 9 bits.
// - match number is meaningful only while FIFO not-empty flag is set.
// - ten-bit prescaler divides the clock to make the time quantum.
// - jump width equals programmed field plus one quanta.
// - propagation segment equals programmed field plus one quanta.
// - first phase segment equals programmed field plus one quanta.
// - second phase segment equals programmed field plus one quanta.
// - bit timing survives soft reset; only hardware reset restores defaults.
// - the 32 private masks survive soft reset.
// - masks and bit timing are writable only in inactive mode.
// - 32 private masks at word offsets from 0x880, mailbox or FIFO use.
// - masks live in ram, undefined after reset until software writes them.
module can_crc_filter_bit_timing
(
  // clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_b,
  // avalon-mm slave
  input  wire logic [can_cfbt_pkg::ADDR_W-1:0]       avs_address,
  input  wire logic                                  avs_read,
  input  wire logic                                  avs_write,
  input  wire logic [can_cfbt_pkg::DATA_W-1:0]       avs_writedata,
  input  wire logic [3:0]                            avs_byteenable,
  output logic      [can_cfbt_pkg::DATA_W-1:0]       avs_readdata,
  output logic                                       avs_waitrequest,
  // controller state
  input  wire logic                                  inactiveMode,
  input  wire logic                                  softReset,
  input  wire logic                                  rxFifoNotEmpty,
  // transmit completion
  input  wire logic                                  txDone,
  input  wire logic [can_cfbt_pkg::CRC_W-1:0]        txCrc,
  input  wire logic [can_cfbt_pkg::MBOX_W-1:0]       txMailbox,
  // fifo output message match
  input  wire logic                                  fifoLoad,
  input  wire logic [31:0]                           elementHit,
  input  wire logic [can_cfbt_pkg::GROUP_W-1:0]      hitGroup,
  // identifier compare
  input  wire logic                                  cmpStart,
  input  wire logic [31:0]                           cmpId,
  input  wire logic [31:0]                           cmpElem,
  input  wire logic [31:0]                           cmpReserved,
  input  wire logic [can_cfbt_pkg::PMASK_IW-1:0]     cmpElemIdx,
  input  wire logic                                  cmpPrivate,
  output logic                                       cmpDone,
  output logic                                       cmpHit,
  // match report
  output logic      [can_cfbt_pkg::HIT_W-1:0]        hitIndex,
  output logic                                       hitIndexValid,
  // bit timing
  output logic                                       tqTick,
  output logic                                       bitStart,
  output logic                                       samplePoint,
  output logic      [5:0]                            sjwTq
);
  import can_cfbt_pkg::*;

  // =====================================================
  // bus handshake
  logic              waitReq_ff;
  logic [31:0]       rdData_ff;
  logic              busReq;
  logic              firstCyc;
  logic              accept;
  logic              wordWr;
  logic              cfgWr;

  // one wait state: data is looked up in the first cycle,
  // then waitrequest drops for exactly one cycle
  assign busReq   = avs_read | avs_write;
  assign firstCyc = busReq && waitReq_ff;
  assign accept   = busReq && !waitReq_ff;
  assign wordWr   = avs_write && accept && (avs_byteenable == BE_FULL);
  assign cfgWr    = wordWr && inactiveMode;

  // =====================================================
  // address decode
  logic selCrc;
  logic selCm;
  logic selHit;
  logic selBt;
  logic selPm;
  logic anySel;

  assign selCrc = (avs_address == OFS_CRC);
  assign selCm  = (avs_address == OFS_CMASK);
  assign selHit = (avs_address == OFS_HIT);
  assign selBt  = (avs_address == OFS_BT);
  assign selPm  = (avs_address[ADDR_W-1:PMASK_HI] == OFS_PMASK[ADDR_W-1:PMASK_HI])
                  && (avs_address[1:0] == 2'b00);
  assign anySel = selCrc | selCm | selHit | selBt | selPm;

  // =====================================================
  // transmit crc status
  logic [CRC_W-1:0]  crc_ff;
  logic [MBOX_W-1:0] mbox_ff;

  // a completion in the soft reset cycle still lands
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      crc_ff  <= CRC_RESET;
      mbox_ff <= MBOX_RESET;
    end
    else if (txDone)
    begin
      crc_ff  <= txCrc;
      mbox_ff <= txMailbox;
    end
    else if (softReset)
    begin
      crc_ff  <= CRC_RESET;
      mbox_ff <= MBOX_RESET;
    end
  end

  // =====================================================
  // common fifo mask, ram backed
  logic [31:0] cmMask_ff;

  always_ff @(posedge clk_sys)
  begin
    if (cfgWr && selCm) cmMask_ff <= avs_writedata;
  end

  // =====================================================
  // nominal bit timing, hardware reset only
  logic [31:0] bt_ff;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b) bt_ff <= BT_RESET;
    else if (cfgWr && selBt) bt_ff <= avs_writedata & BT_WMASK;
  end

  // =====================================================
  // private masks
  logic [31:0] pmRdA;
  logic [31:0] pmRdB;
  logic        pmWr;

  assign pmWr = cfgWr && selPm;

  private_mask_ram u_pmask (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wrEn    (pmWr),
    .wrIdx   (avs_address[PMASK_HI-1:2]),
    .wrData  (avs_writedata),
    .rdIdxA  (avs_address[PMASK_HI-1:2]),
    .rdDataA (pmRdA),
    .rdIdxB  (cmpElemIdx),
    .rdDataB (pmRdB)
  );

  // =====================================================
  // identifier compare against element
  logic [31:0] cmpMask;
  logic [31:0] cmpCare;
  logic        cmpMatch;
  logic        cmpDone_ff;
  logic        cmpHit_ff;

  // private mask when the element has one, else the common one
  assign cmpMask  = cmpPrivate ? pmRdB : cmMask_ff;
  assign cmpCare  = cmpMask & ~cmpReserved;
  assign cmpMatch = ((cmpId ^ cmpElem) & cmpCare) == 32'h0;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cmpDone_ff <= 1'b0;
      cmpHit_ff  <= 1'b0;
    end
    else
    begin
      cmpDone_ff <= cmpStart;
      if (cmpStart) cmpHit_ff <= cmpMatch;
    end
  end

  // =====================================================
  // match number of fifo output message
  logic [HIT_W-1:0] hitIndex_ff;
  logic             hitValid_ff;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      hitIndex_ff <= HIT_RESET;
      hitValid_ff <= 1'b0;
    end
    else
    begin
      if (fifoLoad && |elementHit)
        hitIndex_ff <= {hitGroup, lowest_hit(elementHit)};
      hitValid_ff <= rxFifoNotEmpty;
    end
  end

  // =====================================================
  // read mux and bus registers
  logic [31:0] rdMux;

  assign rdMux = selCrc ? {11'h000, mbox_ff, 1'b0, crc_ff} :
                 selCm  ? cmMask_ff :
                 selHit ? {23'h000000, hitIndex_ff} :
                 selBt  ? bt_ff :
                 selPm  ? pmRdA : RD_NONE;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      waitReq_ff <= 1'b1;
      rdData_ff  <= RD_NONE;
    end
    else
    begin
      waitReq_ff <= !firstCyc;
      if (firstCyc) rdData_ff <= avs_read ? rdMux : RD_NONE;
    end
  end

  // =====================================================
  // timing generator
  logic       tqTick_w;
  logic       bitStart_w;
  logic       samplePoint_w;
  logic [5:0] sjwTq_w;

  // counting stops while inactive so a new setting starts clean
  bit_time_gen u_btg (
    .clk_sys        (clk_sys),
    .rst_b          (rst_b),
    .run            (!inactiveMode),
    .prescaler      (bt_ff[PSC_LSB +: PSC_W]),
    .propField      (bt_ff[PROP_LSB +: PROP_W]),
    .ph1Field       (bt_ff[PH1_LSB +: SEG_W]),
    .ph2Field       (bt_ff[PH2_LSB +: SEG_W]),
    .sjwField       (bt_ff[SJW_LSB +: SEG_W]),
    .tqTick_ff      (tqTick_w),
    .bitStart_ff    (bitStart_w),
    .samplePoint_ff (samplePoint_w),
    .sjwTq_ff       (sjwTq_w),
    .seg_ff         ()
  );

  // =====================================================
  // outputs
  assign avs_readdata    = rdData_ff;
  assign avs_waitrequest = waitReq_ff;
  assign cmpDone         = cmpDone_ff;
  assign cmpHit          = cmpHit_ff;
  assign hitIndex        = hitIndex_ff;
  assign hitIndexValid   = hitValid_ff;
  assign tqTick          = tqTick_w;
  assign bitStart        = bitStart_w;
  assign samplePoint     = samplePoint_w;
  assign sjwTq           = sjwTq_w;

  // =====================================================
  // checks
  sequence reqWait;
    busReq && waitReq_ff;
  endsequence

  sequence oneGrant;
    !waitReq_ff ##1 waitReq_ff;
  endsequence

  bus_grant_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reqWait |=> oneGrant)
    else $error("waitrequest did not pulse low once");
  unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    avs_read && accept && !anySel |-> rdData_ff == RD_NONE)
    else $error("unmapped read not zero");
  crc_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    txDone |=> crc_ff == $past(txCrc) && mbox_ff == $past(txMailbox))
    else $error("tx crc or mailbox not captured");
  crc_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    avs_read && accept && selCrc && $stable(crc_ff) && $stable(mbox_ff)
      |-> rdData_ff[20:16] == mbox_ff && rdData_ff[14:0] == crc_ff)
    else $error("crc status reads wrong");
  inactive_lock_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !inactiveMode |=> $stable(bt_ff) && $stable(cmMask_ff))
    else $error("config changed outside inactive mode");
  bt_soft_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    softReset && !(cfgWr && selBt) |=> $stable(bt_ff))
    else $error("bit timing hit by soft reset");
  hit_lowest_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fifoLoad && |elementHit |=> ((($past(elementHit) >> hitIndex_ff[4:0]) & 32'h1) == 32'h1)
      && (($past(elementHit) & ((32'h1 << hitIndex_ff[4:0]) - 32'h1)) == 32'h0)
      && (hitIndex_ff[8:5] == $past(hitGroup)))
    else $error("match number not lowest hit");
  hit_valid_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 hitValid_ff == $past(rxFifoNotEmpty))
    else $error("match valid does not follow not-empty");
  dont_care_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cmpStart && cmpCare == 32'h0 |=> cmpHit_ff && cmpDone_ff)
    else $error("masked compare did not hit");

endmodule // can_crc_filter_bit_timing
`default_nettype wire

/* File: design/can_cfbt_pkg.sv */
package can_cfbt_pkg;

  // =====================================================
  // bus and register map
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam logic [11:0] OFS_CRC     = 12'h044;
  localparam logic [11:0] OFS_CMASK   = 12'h048;
  localparam logic [11:0] OFS_HIT     = 12'h04C;
  localparam logic [11:0] OFS_BT      = 12'h050;
  localparam logic [11:0] OFS_PMASK   = 12'h880;
  localparam int          PMASK_CNT   = 32;
  localparam int          PMASK_IW    = 5;
  localparam int          PMASK_HI    = 7;
  localparam logic [3:0]  BE_FULL     = 4'hF;
  localparam logic [31:0] RD_NONE     = 32'h0000_0000;

  // =====================================================
  // field layouts and reset values
  localparam int          CRC_LSB     = 0;
  localparam int          CRC_W       = 15;
  localparam int          MBOX_LSB    = 16;
  localparam int          MBOX_W      = 5;
  localparam int          HIT_W       = 9;
  localparam int          GROUP_W     = 4;
  localparam int          PSC_LSB     = 21;
  localparam int          PSC_W       = 10;
  localparam int          SJW_LSB     = 16;
  localparam int          PROP_LSB    = 10;
  localparam int          PROP_W      = 6;
  localparam int          PH1_LSB     = 5;
  localparam int          PH2_LSB     = 0;
  localparam int          SEG_W       = 5;
  localparam int          LEN_W       = 7;
  localparam logic [31:0] BT_RESET    = 32'h0100_0000;
  localparam logic [31:0] BT_WMASK    = 32'h7FFF_FFFF;
  localparam logic [14:0] CRC_RESET   = 15'h0000;
  localparam logic [4:0]  MBOX_RESET  = 5'h00;
  localparam logic [8:0]  HIT_RESET   = 9'h000;

  // =====================================================
  // nominal bit segments, gray along the bit
  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_PROP = 2'b01,
    SEG_PH1  = 2'b11,
    SEG_PH2  = 2'b10
  } seg_t;

  // programmed field plus one, in quanta
  function automatic logic [6:0] seg_len(input logic [5:0] f);
    seg_len = {1'b0, f} + 7'h01;
  endfunction

  // lowest set bit of a hit vector
  function automatic logic [4:0] lowest_hit(input logic [31:0] v);
    lowest_hit = 5'h00;
    for (int i = 31; i >= 0; i--)
      if (v[i]) lowest_hit = 5'(i);
  endfunction

endpackage

/* File: design/private_mask_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module private_mask_ram
  import can_cfbt_pkg::*;
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // write port
  input  wire logic                wrEn,
  input  wire logic [PMASK_IW-1:0] wrIdx,
  input  wire logic [DATA_W-1:0]   wrData,
  // read ports
  input  wire logic [PMASK_IW-1:0] rdIdxA,
  output logic      [DATA_W-1:0]   rdDataA,
  input  wire logic [PMASK_IW-1:0] rdIdxB,
  output logic      [DATA_W-1:0]   rdDataB
);

  // =====================================================
  // storage
  // plain ram: no reset, so soft reset cannot touch it either
  logic [DATA_W-1:0] mem [PMASK_CNT];

  always_ff @(posedge clk_sys)
  begin
    if (wrEn) mem[wrIdx] <= wrData;
  end

  assign rdDataA = mem[rdIdxA];
  assign rdDataB = mem[rdIdxB];

  // =====================================================
  // checks
  ram_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wrEn |=> mem[$past(wrIdx)] == $past(wrData))
    else $error("private mask write lost");

endmodule // private_mask_ram
`default_nettype wire

/* File: design/bit_time_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_time_gen
  import can_cfbt_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  // configuration
  input  wire logic             run,
  input  wire logic [PSC_W-1:0] prescaler,
  input  wire logic [PROP_W-1:0] propField,
  input  wire logic [SEG_W-1:0] ph1Field,
  input  wire logic [SEG_W-1:0] ph2Field,
  input  wire logic [SEG_W-1:0] sjwField,
  // timing strobes
  output logic                  tqTick_ff,
  output logic                  bitStart_ff,
  output logic                  samplePoint_ff,
  output logic      [5:0]       sjwTq_ff,
  output seg_t                  seg_ff
);

  // =====================================================
  // quantum and segment counters
  logic [PSC_W-1:0] pscCnt_ff;
  logic [LEN_W-1:0] tqCnt_ff;
  logic [LEN_W-1:0] curLen;
  logic             tqEnd;
  logic             segLast;
  seg_t             nxt_seg;

  assign tqEnd   = run && (pscCnt_ff == prescaler);
  assign segLast = (tqCnt_ff == curLen - 7'h01);

  always_comb
  begin
    curLen  = 7'h01;
    nxt_seg = SEG_SYNC;
    unique case (seg_ff)
      SEG_SYNC: begin curLen = 7'h01; nxt_seg = SEG_PROP; end
      SEG_PROP: begin curLen = seg_len(propField); nxt_seg = SEG_PH1; end
      SEG_PH1:  begin curLen = seg_len({1'b0, ph1Field}); nxt_seg = SEG_PH2; end
      SEG_PH2:  begin curLen = seg_len({1'b0, ph2Field}); nxt_seg = SEG_SYNC; end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !run)
    begin
      pscCnt_ff <= '0;
      tqCnt_ff  <= '0;
      seg_ff    <= SEG_SYNC;
    end
    else
    begin
      pscCnt_ff <= tqEnd ? '0 : pscCnt_ff + 10'h001;
      if (tqEnd) tqCnt_ff <= segLast ? '0 : tqCnt_ff + 7'h01;
      if (tqEnd && segLast) seg_ff <= nxt_seg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      tqTick_ff      <= 1'b0;
      bitStart_ff    <= 1'b0;
      samplePoint_ff <= 1'b0;
      sjwTq_ff       <= 6'h01;
    end
    else
    begin
      tqTick_ff      <= tqEnd;
      bitStart_ff    <= tqEnd && segLast && (seg_ff == SEG_PH2);
      samplePoint_ff <= tqEnd && segLast && (seg_ff == SEG_PH1);
      sjwTq_ff       <= {1'b0, sjwField} + 6'h01;
    end
  end

  // =====================================================
  // checks
  bit_sync_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bitStart_ff |-> seg_ff == SEG_SYNC)
    else $error("bit start outside sync segment");
  sample_ph2_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    samplePoint_ff |-> seg_ff == SEG_PH2)
    else $error("sample point not at end of phase one");
  sjw_plus_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 sjwTq_ff == {1'b0, $past(sjwField)} + 6'h01)
    else $error("jump width not field plus one");
  tq_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tqTick_ff && run && $stable(run) && prescaler != 10'h000 |=> !tqTick_ff)
    else $error("quantum shorter than prescaler");

endmodule // bit_time_gen
`default_nettype wire

/* File: tb/can_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model
(
  // clock
  input  wire logic                                clk_sys,
  // transmit completion
  output logic                                     txDone,
  output logic      [can_cfbt_pkg::CRC_W-1:0]      txCrc,
  output logic      [can_cfbt_pkg::MBOX_W-1:0]     txMailbox,
  // fifo output message
  output logic                                     fifoLoad,
  output logic      [31:0]                         elementHit,
  output logic      [can_cfbt_pkg::GROUP_W-1:0]    hitGroup,
  output logic                                     rxFifoNotEmpty
);
  import can_cfbt_pkg::*;

  // =====================================================
  // idle values
  initial
  begin
    txDone         = 1'b0;
    txCrc          = 15'h0000;
    txMailbox      = 5'h00;
    fifoLoad       = 1'b0;
    elementHit     = 32'h0000_0000;
    hitGroup       = 4'h0;
    rxFifoNotEmpty = 1'b0;
  end

  // =====================================================
  // one successful classical transmit; data lines invert after, not held
  task automatic send_tx(input logic [14:0] c, input logic [4:0] m);
    txDone    <= 1'b1;
    txCrc     <= c;
    txMailbox <= m;
    @(posedge clk_sys);
    txDone    <= 1'b0;
    txCrc     <= ~c;
    txMailbox <= ~m;
  endtask

  // message reaches the fifo output, fifo no longer empty
  task automatic load_fifo(input logic [31:0] h, input logic [3:0] g);
    fifoLoad       <= 1'b1;
    elementHit     <= h;
    hitGroup       <= g;
    rxFifoNotEmpty <= 1'b1;
    @(posedge clk_sys);
    fifoLoad       <= 1'b0;
    elementHit     <= ~h;
    hitGroup       <= ~g;
  endtask

  // last message read out, match number loses meaning
  task automatic pop_fifo();
    rxFifoNotEmpty <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule // can_ctrl_model
`default_nettype wire

/* File: tb/can_crc_filter_bit_timing_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module can_crc_filter_bit_timing_tb_top;
  import can_cfbt_pkg::*;

  // =====================================================
  // signals
  logic        clk_sys, rst_b, avs_read, avs_write, avs_waitrequest, inactiveMode, softReset;
  logic        txDone, fifoLoad, rxFifoNotEmpty, cmpStart, cmpPrivate, cmpDone, cmpHit;
  logic        hitIndexValid, tqTick, bitStart, samplePoint, ex;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, seed, cmask, bt, v, h;
  logic [31:0] elementHit, cmpId, cmpElem, cmpReserved, pm [32];
  logic [3:0]  avs_byteenable, hitGroup;
  logic [14:0] txCrc;
  logic [4:0]  txMailbox, cmpElemIdx;
  logic [8:0]  hitIndex;
  logic [5:0]  sjwTq;
  int          fails, num_checks, n, sinceBit, sinceTq, bitGap, spGap, tqGap;

  can_crc_filter_bit_timing i_dut (.*);
  can_ctrl_model i_model (.clk_sys(clk_sys), .txDone(txDone), .txCrc(txCrc),
    .txMailbox(txMailbox), .fifoLoad(fifoLoad), .elementHit(elementHit),
    .hitGroup(hitGroup), .rxFifoNotEmpty(rxFifoNotEmpty));

  always #4 clk_sys = ~clk_sys;

  // =====================================================
  // gaps between timing strobes, in clocks
  always @(posedge clk_sys)
  begin
    sinceBit++;
    sinceTq++;
    if (samplePoint === 1'b1) spGap = sinceBit;
    if (bitStart === 1'b1)
    begin
      bitGap = sinceBit;
      sinceBit = 0;
    end
    if (tqTick === 1'b1)
    begin
      tqGap = sinceTq;
      sinceTq = 0;
    end
  end

  // =====================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [4:0] low(input logic [31:0] x);
    low = 5'h00;
    for (int i = 31; i >= 0; i--)
      if (x[i]) low = 5'(i);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one avalon access; holds everything until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    n = 0;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      fails++;
      results();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, BE_FULL);
    chk(rd, exp);
  endtask

  task automatic soft_pulse();
    softReset <= 1'b1;
    @(posedge clk_sys);
    softReset <= 1'b0;
    @(posedge clk_sys);
  endtask

  // =====================================================
  // main sequence
  initial
  begin
    {clk_sys, rst_b, avs_read, avs_write, softReset, cmpStart, cmpPrivate} = '0;
    {avs_address, avs_writedata, avs_byteenable, cmpId, cmpElem, cmpReserved, cmpElemIdx} = '0;
    {fails, num_checks, sinceBit, sinceTq, bitGap, spGap, tqGap} = '0;
    inactiveMode = 1'b1;
    seed = 32'h0000_029D;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rdchk(OFS_CRC, 32'h0000_0000);
    rdchk(OFS_BT, BT_RESET);
    chk(32'(sjwTq), 32'h0000_0001);
    rdchk(12'h100, RD_NONE);
    $display("test reset done");

    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 32'hFFFF_FFFF : rnd();
      bus(1'b1, OFS_BT, v, BE_FULL);
      rdchk(OFS_BT, v & BT_WMASK);
      chk(32'(sjwTq), 32'(v[20:16]) + 32'h1);
    end
    bt = v & BT_WMASK;
    bus(1'b1, OFS_BT, ~v, 4'h3);
    rdchk(OFS_BT, bt);
    bus(1'b1, OFS_CRC, rnd(), BE_FULL);
    rdchk(OFS_CRC, 32'h0000_0000);
    $display("test timing regs done");

    for (int i = 0; i < PMASK_CNT; i++)
    begin
      pm[i] = rnd();
      bus(1'b1, OFS_PMASK + 12'(i * 4), pm[i], BE_FULL);
    end
    cmask = rnd();
    bus(1'b1, OFS_CMASK, cmask, BE_FULL);
    soft_pulse();
    for (int i = 0; i < PMASK_CNT; i++)
      rdchk(OFS_PMASK + 12'(i * 4), pm[i]);
    rdchk(OFS_BT, bt);
    rdchk(OFS_CMASK, cmask);
    $display("test masks done");

    repeat (6)
    begin
      v = rnd();
      i_model.send_tx(v[14:0], v[20:16]);
      @(posedge clk_sys);
      rdchk(OFS_CRC, {11'h000, v[20:16], 1'b0, v[14:0]});
    end
    $display("test tx crc done");

    for (int i = 0; i < 6; i++)
    begin
      h = (i == 0) ? 32'h8000_0000 : (i == 1) ? 32'hFFFF_FFFF : rnd() | 32'h0010_0000;
      v = rnd();
      i_model.load_fifo(h, v[3:0]);
      @(posedge clk_sys);
      rdchk(OFS_HIT, {23'h000000, v[3:0], low(h)});
      chk(32'(hitIndex), {23'h000000, v[3:0], low(h)});
      chk(32'(hitIndexValid), 32'h0000_0001);
      i_model.pop_fifo();
      @(posedge clk_sys);
      chk(32'(hitIndexValid), 32'h0000_0000);
    end
    $display("test match number done");

    // first pass: every bit reserved, so nothing is compared
    for (int i = 0; i < 24; i++)
    begin
      v = rnd();
      cmpId       <= v;
      cmpElem     <= v ^ (rnd() & rnd() & rnd());
      cmpReserved <= (i == 0) ? 32'hFFFF_FFFF : rnd() & rnd();
      cmpPrivate  <= seed[7];
      cmpElemIdx  <= seed[4:0];
      cmpStart    <= 1'b1;
      @(posedge clk_sys);
      cmpStart <= 1'b0;
      ex = ((cmpId ^ cmpElem) & (cmpPrivate ? pm[cmpElemIdx] : cmask) & ~cmpReserved) == 0;
      n = 0;
      do
      begin
        @(posedge clk_sys);
        n++;
      end while (cmpDone !== 1'b1 && n < 5);
      chk(32'(cmpDone), 32'h0000_0001);
      chk(32'(cmpHit), 32'(ex));
    end
    $display("test compare done");

    // short bit: 7 quanta of 2 clocks
    bt = {1'b0, 10'h001, 5'h02, 6'h01, 5'h00, 5'h02};
    bus(1'b1, OFS_BT, bt, BE_FULL);
    inactiveMode <= 1'b0;
    repeat (60) @(posedge clk_sys);
    bus(1'b1, OFS_BT, 32'h0000_0000, BE_FULL);
    repeat (40) @(posedge clk_sys);
    chk(32'(bitGap), 32'd14);
    chk(32'(spGap), 32'd8);
    chk(32'(tqGap), 32'd2);
    inactiveMode <= 1'b1;
    @(posedge clk_sys);
    rdchk(OFS_BT, bt);
    $display("test bit generator done");

    // hardware reset while inactive brings the defaults back
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rdchk(OFS_BT, BT_RESET);
    rdchk(OFS_CRC, 32'h0000_0000);
    chk(32'(sjwTq), 32'h0000_0001);
    $display("test hard reset done");
    results();
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    results();
  end
endmodule // can_crc_filter_bit_timing_tb_top
`default_nettype wire
